//--- hdl/fault_ctrl_regs.vh
// Register map, field positions and timing constants of the fault logic
`ifndef FAULT_CTRL_REGS_VH
`define FAULT_CTRL_REGS_VH
// Byte offsets
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_IRQ_STAT 12'h008
`define REG_IRQ_MASK 12'h00C
`define REG_STRING_OFF 12'h010
// Control fields
`define CTRL_SHUTDOWN_ALL 0
`define CTRL_STRING_EN_LO 8
`define CTRL_RESET 32'h0000_3F00
// Status fields
`define ST_FAULT_OUT 0
`define ST_EXT_LOW 1
`define ST_BOOST_ON 2
`define ST_LATCHED 3
`define ST_STR_LO 8
// Interrupt bits
`define IRQ_PS_DETECT 0
`define IRQ_FAULT_REL 1
`define IRQ_EXT_LOW 2
`define IRQ_WIDTH 3
// Timing
`define DETECT_TIME_NS 2000
`define CLK_PERIOD_NS 40
`define RESET_HOLD_US 16000
`endif

//--- hdl/string_monitor.v
// Partial-short detection and retry state for one LED string
`timescale 1ns/1ps
`default_nettype none
module string_monitor #(
  parameter DETECT_CYCLES = 50,
  parameter CW = 8
) (
  // Clock and reset
  input wire core_clk,
  input wire rstn,
  // Control
  input wire enable,
  input wire pwmRise,
  input wire pwmHigh,
  input wire overThreshold,
  input wire otherInReg,
  // Results
  output reg disabled,
  output reg faultHold,
  output reg detectPulse
);
  localparam ST_OK = 2'd0;
  localparam ST_OFF = 2'd1;
  localparam ST_PASS1 = 2'd2;

  reg [1:0] state;
  reg [CW-1:0] count;
  reg retryFailed;
  wire cond;

  // Condition only evaluated while PWM is high
  assign cond = pwmHigh && overThreshold && otherInReg;

  always @(posedge core_clk) begin
    if (!rstn || !enable) begin
      state <= ST_OK;
      count <= {CW{1'b0}};
      disabled <= 1'b0;
      faultHold <= 1'b0;
      detectPulse <= 1'b0;
      retryFailed <= 1'b0;
    end else begin
      detectPulse <= 1'b0;
      if (!cond || pwmRise)
        count <= {CW{1'b0}};
      else if (count != DETECT_CYCLES[CW-1:0])
        count <= count + {{(CW-1){1'b0}}, 1'b1};
      case (state)
        ST_OK: begin
          if (cond && count == DETECT_CYCLES[CW-1:0] - 1'b1) begin
            state <= ST_OFF;
            disabled <= 1'b1;
            faultHold <= 1'b1;
            detectPulse <= 1'b1;
          end
        end
        ST_OFF: begin
          if (pwmRise) begin
            // Retry: sink comes back and is judged again
            disabled <= 1'b0;
            retryFailed <= 1'b0;
          end else if (!disabled && cond &&
              count == DETECT_CYCLES[CW-1:0] - 1'b1) begin
            disabled <= 1'b1;
            retryFailed <= 1'b1;
          end else if (!disabled && !pwmHigh && !retryFailed) begin
            // Whole high phase passed: string stays on, flag held
            state <= ST_PASS1;
          end
        end
        ST_PASS1: begin
          if (cond && count == DETECT_CYCLES[CW-1:0] - 1'b1) begin
            state <= ST_OFF;
            disabled <= 1'b1;
            retryFailed <= 1'b1;
          end else if (pwmRise) begin
            state <= ST_OK;
            faultHold <= 1'b0;
          end
        end
        default: state <= ST_OK;
      endcase
    end
  end
endmodule
`default_nettype wire

//--- hdl/led_fault_ctrl.v
// Fault-line handling and partial-short supervision with APB registers
//
// Functional notes
// - Isolate-string option ignores any external level on the fault line.
// - Shutdown-all option both drives and senses the fault line.
// - External low in shutdown-all stops boost and sinks, disconnect stays on.
// - Restart only when external low gone and no local fault latched.
// - Partial short during PWM low causes nothing until next PWM high.
// - Short: pin above threshold while another string's sink regulates.
// - After detection time, disable string and pull fault line low.
// - Isolate option: healthy strings keep sinking current when another is disabled.
// - Isolate option: each later PWM high retries the string; fault line stays low.
// - Isolate option: first PWM high after removal re-enables string, flag kept low.
// - Isolate option: fault line released at second PWM high after removal.
// - Isolate option needs another LED pin below regulation level.
`timescale 1ns/1ps
`default_nettype none
`include "fault_ctrl_regs.vh"
module led_fault_ctrl #(
  parameter NUM_STR = 6,
  parameter RESET_HOLD_CYCLES = (`RESET_HOLD_US * 1000) / `CLK_PERIOD_NS
) (
  // Clock and reset
  input wire core_clk,
  input wire rstn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata,
  // Dimming and enable inputs
  input wire pwmIn,
  input wire enIn,
  // Analog comparator results per string
  input wire [NUM_STR-1:0] overThreshold,
  input wire [NUM_STR-1:0] sinkInReg,
  input wire [NUM_STR-1:0] belowRegLevel,
  // Latching internal fault from elsewhere in the device
  input wire localLatchFault,
  // Open-drain fault line
  input wire faultIn,
  output wire faultOut,
  output wire faultOe,
  // Power stage controls
  output reg boostEnable,
  output reg disconnectOn,
  output reg [NUM_STR-1:0] sinkEnable,
  // Interrupt
  output wire irq
);
  localparam DETECT_CYCLES =
    (`DETECT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam HOLD_W = 20;

  function [NUM_STR-1:0] othersAny;
    input [NUM_STR-1:0] v;
    input integer idx;
    reg [NUM_STR-1:0] m;
    begin
      m = v;
      m[idx] = 1'b0;
      othersAny = m;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Registers
  reg [31:0] ctrl;
  reg [`IRQ_WIDTH-1:0] irqStat;
  reg [`IRQ_WIDTH-1:0] irqMask;
  reg pwmDly;
  reg latched;
  reg [HOLD_W-1:0] holdCnt;
  reg extLowDly;
  reg faultDriveDly;

  wire shutdownAll = ctrl[`CTRL_SHUTDOWN_ALL];
  wire [NUM_STR-1:0] strEn = ctrl[`CTRL_STRING_EN_LO +: NUM_STR];
  wire pwmRise = pwmIn && !pwmDly;
  wire [NUM_STR-1:0] disabled;
  wire [NUM_STR-1:0] faultHold;
  wire [NUM_STR-1:0] detect;
  wire anyHold = |faultHold;
  wire faultDrive = anyHold || latched;
  // Own drive excluded, but faultOe lags faultDrive a cycle, so the device trips on its own low in the cycle after release
  wire extLow = shutdownAll && !faultIn && !faultDrive;
  wire apbWr = psel && penable && pwrite;

  ////////////////////////////////////////////////////////////////////
  // Per-string monitors
  genvar g;
  generate
    for (g = 0; g < NUM_STR; g = g + 1) begin : gStr
      wire otherOk;
      // Isolate option also demands another pin below regulation level
      assign otherOk = (|othersAny(sinkInReg, g)) &&
        (shutdownAll || (|othersAny(belowRegLevel, g)));
      string_monitor #(
        .DETECT_CYCLES(DETECT_CYCLES),
        .CW(8)
      ) uMon (
        .core_clk(core_clk),
        .rstn(rstn),
        .enable(strEn[g]),
        .pwmRise(pwmRise),
        .pwmHigh(pwmIn),
        .overThreshold(overThreshold[g]),
        .otherInReg(otherOk),
        .disabled(disabled[g]),
        .faultHold(faultHold[g]),
        .detectPulse(detect[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Latch of local faults and its reset by a long low on enable or PWM
  always @(posedge core_clk) begin
    if (!rstn) begin
      pwmDly <= 1'b0;
      latched <= 1'b0;
      holdCnt <= {HOLD_W{1'b0}};
      extLowDly <= 1'b0;
      faultDriveDly <= 1'b0;
    end else begin
      pwmDly <= pwmIn;
      extLowDly <= extLow;
      faultDriveDly <= faultDrive;
      if (enIn && pwmIn)
        holdCnt <= {HOLD_W{1'b0}};
      else if (holdCnt != RESET_HOLD_CYCLES[HOLD_W-1:0])
        holdCnt <= holdCnt + {{(HOLD_W-1){1'b0}}, 1'b1};
      // A new fault wins over the timed clear
      if (localLatchFault || (shutdownAll && |detect))
        latched <= 1'b1;
      else if (holdCnt == RESET_HOLD_CYCLES[HOLD_W-1:0])
        latched <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Power stage outputs
  always @(posedge core_clk) begin
    if (!rstn) begin
      boostEnable <= 1'b0;
      disconnectOn <= 1'b0;
      sinkEnable <= {NUM_STR{1'b0}};
    end else begin
      disconnectOn <= 1'b1;
      // External low acts at once; local latch blocks restart
      if (extLow || latched) begin
        boostEnable <= 1'b0;
        sinkEnable <= {NUM_STR{1'b0}};
      end else begin
        boostEnable <= 1'b1;
        sinkEnable <= strEn & ~disabled;
      end
    end
  end

  // Output enable low while pulling the line low
  assign faultOut = 1'b0;
  assign faultOe = !faultDriveDly;

  ////////////////////////////////////////////////////////////////////
  // Interrupts
  wire [`IRQ_WIDTH-1:0] irqSet = {extLow && !extLowDly,
    faultDriveDly && !faultDrive, |detect};
  always @(posedge core_clk) begin
    if (!rstn) begin
      irqStat <= {`IRQ_WIDTH{1'b0}};
    end else begin
      if (apbWr && paddr == `REG_IRQ_STAT)
        irqStat <= (irqStat & ~pwdata[`IRQ_WIDTH-1:0]) | irqSet;
      else
        irqStat <= irqStat | irqSet;
    end
  end
  assign irq = |(irqStat & irqMask);

  ////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  always @(posedge core_clk) begin
    if (!rstn) begin
      ctrl <= `CTRL_RESET;
      irqMask <= {`IRQ_WIDTH{1'b0}};
    end else if (apbWr) begin
      case (paddr)
        `REG_CTRL: ctrl <= pwdata;
        `REG_IRQ_MASK: irqMask <= pwdata[`IRQ_WIDTH-1:0];
        default: ;
      endcase
    end
  end

  always @* begin
    prdata = 32'h0000_0000;
    case (paddr)
      `REG_CTRL: prdata = ctrl;
      `REG_STATUS: begin
        prdata[`ST_FAULT_OUT] = faultDriveDly;
        prdata[`ST_EXT_LOW] = extLow;
        prdata[`ST_BOOST_ON] = boostEnable;
        prdata[`ST_LATCHED] = latched;
        prdata[`ST_STR_LO +: NUM_STR] = sinkEnable;
      end
      `REG_IRQ_STAT: prdata[`IRQ_WIDTH-1:0] = irqStat;
      `REG_IRQ_MASK: prdata[`IRQ_WIDTH-1:0] = irqMask;
      `REG_STRING_OFF: prdata[NUM_STR-1:0] = disabled;
      default: prdata = 32'h0000_0000;
    endcase
  end
endmodule
`default_nettype wire

//--- tb/fault_line_model.sv
// Other party on the shared open-drain fault line, with its pull-up
`timescale 1ns/1ps
`default_nettype none
module fault_line_model (
  // Device side
  input wire logic faultOe,
  input wire logic faultOut,
  // Far side
  input wire logic pullLow,
  output wire logic faultIn
);
  // Pull-up wins unless a party sinks the line
  assign faultIn = !(pullLow || (!faultOe && !faultOut));
endmodule
`default_nettype wire

//--- tb/fault_ctrl_monitor.sv
// Port checks for the fault logic
`timescale 1ns/1ps
`default_nettype none
module fault_ctrl_monitor #(parameter NUM_STR = 6) (
  // Clock, reset, APB
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins
  input wire logic pwmIn,
  input wire logic localLatchFault,
  input wire logic faultIn,
  input wire logic faultOut,
  input wire logic faultOe,
  input wire logic boostEnable,
  input wire logic disconnectOn,
  input wire logic [NUM_STR-1:0] sinkEnable
);
  logic mode;
  logic sawLocal;
  logic [7:0] hiCnt;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Option bit mirrored at the edge the register takes it
  always @(posedge core_clk) begin
    if (!rstn) begin
      mode <= 1'b0;
      sawLocal <= 1'b0;
      hiCnt <= 8'h00;
    end else begin
      if (psel && penable && pwrite && paddr == 12'h000) mode <= pwdata[0];
      if (localLatchFault) sawLocal <= 1'b1;
      hiCnt <= !pwmIn ? 8'h00 : (hiCnt == 8'hFF ? hiCnt : hiCnt + 8'h01);
    end
  end
  chk_ready_high: assert property (pready) else $error("pready low");
  chk_no_slverr: assert property (!pslverr) else $error("pslverr high");
  chk_od_zero: assert property (!faultOut) else $error("line high");
  chk_disc_kept: assert property ($past(rstn) |-> disconnectOn)
    else $error("disconnect off");
  chk_ext_shut: assert property (mode && !faultIn && faultOe |=>
    !boostEnable && sinkEnable == '0) else $error("no shutdown");
  chk_iso_ignore: assert property (!mode && !faultIn |=> boostEnable)
    else $error("isolate reacted");
  chk_detect_time: assert property ($fell(faultOe) && !sawLocal |->
    $past(hiCnt, 2) >= 8'd48) else $error("detect too early");
  chk_release_pwm: assert property (!mode && $rose(faultOe) |-> pwmIn)
    else $error("release off pwm high");
endmodule
bind led_fault_ctrl fault_ctrl_monitor #(.NUM_STR(NUM_STR)) mon (
  .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .pwmIn(pwmIn), .localLatchFault(localLatchFault),
  .faultIn(faultIn), .faultOut(faultOut), .faultOe(faultOe),
  .boostEnable(boostEnable), .disconnectOn(disconnectOn),
  .sinkEnable(sinkEnable));
`default_nettype wire

//--- tb/tb.sv
// Self-checking bench for the LED fault logic
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int HOLD = 20;
  logic core_clk, rstn, psel, penable, pwrite, pwmIn, enIn, localLatchFault;
  logic pready, pslverr, faultIn, faultOut, faultOe, boostEnable;
  logic disconnectOn, irq, pullLow;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0] overThreshold, sinkInReg, belowRegLevel, sinkEnable;
  integer fail_count = 0;
  integer total_checks = 0;
  integer cycles = 0;
  led_fault_ctrl #(.NUM_STR(6), .RESET_HOLD_CYCLES(HOLD)) dut (
    .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .pwmIn(pwmIn), .enIn(enIn),
    .overThreshold(overThreshold), .sinkInReg(sinkInReg),
    .belowRegLevel(belowRegLevel), .localLatchFault(localLatchFault),
    .faultIn(faultIn), .faultOut(faultOut), .faultOe(faultOe),
    .boostEnable(boostEnable), .disconnectOn(disconnectOn),
    .sinkEnable(sinkEnable), .irq(irq));
  fault_line_model far (.faultOe(faultOe), .faultOut(faultOut),
    .pullLow(pullLow), .faultIn(faultIn));
  initial begin
    core_clk = 0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      test_done();
    end
  end
  task test_done;
    if (fail_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // Starts just after an edge; slave timing is never assumed
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    integer n;
    begin
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1;
      n = 0;
      do begin
        @(posedge core_clk);
        n++;
      end while (pready !== 1'b1 && n < 100);
      // A slave that never answers counts as a mismatch
      if (pready !== 1'b1) fail_count++;
      rd = prdata;
      psel <= 0;
      penable <= 0;
      @(posedge core_clk);
    end
  endtask
  task ph(input logic v, input integer n);
    pwmIn <= v;
    repeat (n) @(posedge core_clk);
  endtask
  initial begin
    {psel, penable, pwrite, pwmIn, localLatchFault, pullLow} = 0;
    paddr = 0;
    pwdata = 0;
    enIn = 1;
    rstn = 0;
    overThreshold = 0;
    sinkInReg = 6'h3F;
    belowRegLevel = 6'h01;
    repeat (5) @(posedge core_clk);
    rstn <= 1;
    @(posedge core_clk);
    apb(0, 12'h000, 0);
    cmp(rd, 32'h0000_3F00);
    apb(0, 12'h020, 0);
    cmp(rd, 0);
    apb(1, 12'h00C, 32'h0000_0007);
    ph(0, 10);
    overThreshold <= 6'h02;
    ph(0, 20);
    cmp(faultOe, 1);
    ph(1, 60);
    cmp(faultOe, 0);
    cmp(sinkEnable, 6'h3D);
    cmp(irq, 1);
    pullLow <= 1;
    ph(1, 5);
    cmp(boostEnable, 1);
    pullLow <= 0;
    apb(0, 12'h010, 0);
    cmp(rd, 32'h0000_0002);
    ph(0, 10);
    ph(1, 60);
    cmp(faultOe, 0);
    cmp(sinkEnable, 6'h3D);
    ph(0, 5);
    overThreshold <= 0;
    ph(0, 5);
    ph(1, 60);
    cmp(sinkEnable, 6'h3F);
    cmp(faultOe, 0);
    ph(0, 10);
    ph(1, 10);
    cmp(faultOe, 1);
    apb(1, 12'h008, 32'h0000_0007);
    apb(0, 12'h008, 0);
    cmp(rd, 0);
    cmp(irq, 0);
    apb(1, 12'h00C, 0);
    apb(1, 12'h000, 32'h0000_3F01);
    pullLow <= 1;
    ph(1, 3);
    cmp(boostEnable, 0);
    cmp(sinkEnable, 0);
    cmp(disconnectOn, 1);
    cmp(irq, 0);
    apb(0, 12'h008, 0);
    cmp(rd, 32'h0000_0004);
    pullLow <= 0;
    ph(1, 5);
    cmp(boostEnable, 1);
    localLatchFault <= 1;
    ph(1, 1);
    localLatchFault <= 0;
    pullLow <= 1;
    ph(1, 3);
    pullLow <= 0;
    ph(1, 5);
    cmp(boostEnable, 0);
    enIn <= 0;
    ph(1, HOLD + 5);
    enIn <= 1;
    ph(1, 10);
    cmp(boostEnable, 1);
    test_done();
  end
endmodule
`default_nettype wire
